// ===== rtl/shift_unit_pkg.sv
package shift_unit_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [1:0] ADDR_DATA = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_CONTROL = 2'h2;
	localparam logic [1:0] ADDR_PORT = 2'h3;

	// Status register bit positions
	localparam int STAT_START_BIT = 7;
	localparam int STAT_WRAP_BIT = 6;
	localparam int STAT_COLL_BIT = 4;

	// Control register bit positions
	localparam int CTL_START_IE_BIT = 7;
	localparam int CTL_WRAP_IE_BIT = 6;
	localparam int CTL_WM_HI_BIT = 5;
	localparam int CTL_WM_LO_BIT = 4;
	localparam int CTL_EXT_BIT = 3;
	localparam int CTL_EDGE_BIT = 2;
	localparam int CTL_SWCLK_BIT = 1;
	localparam int CTL_TOGGLE_BIT = 0;

	// Port register bit positions
	localparam int PORT_SDA_OUT_BIT = 0;
	localparam int PORT_SCL_OUT_BIT = 1;
	localparam int PORT_SDA_DIR_BIT = 2;
	localparam int PORT_SCL_DIR_BIT = 3;
	localparam int PORT_GIE_BIT = 4;

	// Wire modes
	localparam logic [1:0] WM_OFF = 2'h0;
	localparam logic [1:0] WM_THREE = 2'h1;
	localparam logic [1:0] WM_TWO = 2'h2;
	localparam logic [1:0] WM_TWO_HOLD = 2'h3;

	localparam logic [3:0] CNT_MAX = 4'hF;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'h03;

	// ----------------------------------------
	// Start detector delay
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SDA_DELAY_MIN_NS = 50;
	localparam int SDA_DELAY_CYCLES = (SDA_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Software register bus request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// ===== rtl/start_detector.sv
// ----------------------------------------
// Start condition detector with SDA delay
// ----------------------------------------
module start_detector (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic start_o
);

	logic [shift_unit_pkg::SDA_DELAY_CYCLES-1:0] sda_line;
	logic sda_late;

	// Delay line lets SCL settle before the compare
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sda_line <= '1;
		end else begin
			sda_line <= {sda_line[shift_unit_pkg::SDA_DELAY_CYCLES-2:0], sda_i};
		end
	end

	assign sda_late = sda_line[shift_unit_pkg::SDA_DELAY_CYCLES-1];

	// SDA fall with SCL high, disabled outside two-wire mode
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			start_o <= 1'b0;
		end else begin
			start_o <= enable_i && scl_i && sda_late && !sda_line[shift_unit_pkg::SDA_DELAY_CYCLES-2];
		end
	end

	start_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		start_o |-> $past(enable_i) && $past(scl_i))
		else $error("start seen without enable and high clock");

endmodule // start_detector

// ===== rtl/universal_shift_unit.sv
// Overview of operation
// - Two-wire mode shifts on the serial clock edge chosen by the edge bit
// - Slave stretches clock at byte start/end
// - Data fall with clock high sets flag
// - Data pulled low by top bit or port
// - Start hold keeps clock low until cleared
// - Slave samples data on clock rise with the edge bit clear, on the fall with it set
// - Counter wrap holds clock low until cleared
// - Direction bit chooses who drives data
// - Data delayed before compare with clock
// - Start detector only in two-wire mode
// - Start detection needs the system clock running
// - External clock counts both edges
// - Data register is shift register directly
// - Software write beats coincident shift
// - Left shift from selected clock source
// - Inputs still shift with outputs off
// - Output latch feeds top bit to pin
// - Non two-wire modes flag every count
// - Interrupt when flag and enables set
// - Write one clears start flag, hold
// - Wrap flag on 15 to 0, write-one clear
// - Toggle strobe flips clock pin
module universal_shift_unit (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic timer_match_i,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic data_out_o,
	output logic start_irq_o,
	output logic wrap_irq_o
);

	// ----------------------------------------
	// Bus request and pin synchronisers
	// ----------------------------------------
	shift_unit_pkg::reg_req_t req;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_prev;
	logic [7:0] shift_data;
	logic [3:0] edge_count;
	logic start_detect_flag;
	logic counter_wrap_flag;
	logic start_hold;
	logic wrap_hold;
	logic [7:0] serial_control;
	logic [7:0] port_reg;
	logic out_latch;
	logic start_seen;
	logic scl_rise;
	logic scl_fall;
	logic [1:0] wire_mode_field;
	logic two_wire;
	logic external_clock_select;
	logic clock_edge_select;
	logic wr_data;
	logic wr_status;
	logic wr_control;
	logic software_clock_strobe;
	logic clock_pin_toggle_strobe;
	logic count_tick;
	logic shift_tick;
	logic wrap_now;
	logic scl_pin_level;
	logic latch_open;
	logic [3:0] next_count;

	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

	// Two flops before any logic reads the pins
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			scl_prev <= scl_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] && !scl_prev;
	assign scl_fall = !scl_sync[1] && scl_prev;

	// ----------------------------------------
	// Decode of control fields and strobes
	// ----------------------------------------
	assign wire_mode_field = serial_control[shift_unit_pkg::CTL_WM_HI_BIT:shift_unit_pkg::CTL_WM_LO_BIT];
	assign two_wire = wire_mode_field[1];
	assign external_clock_select = serial_control[shift_unit_pkg::CTL_EXT_BIT];
	assign clock_edge_select = serial_control[shift_unit_pkg::CTL_EDGE_BIT];
	assign wr_data = req.wr && req.addr == shift_unit_pkg::ADDR_DATA;
	assign wr_status = req.wr && req.addr == shift_unit_pkg::ADDR_STATUS;
	assign wr_control = req.wr && req.addr == shift_unit_pkg::ADDR_CONTROL;
	assign software_clock_strobe = wr_control && req.wdata[shift_unit_pkg::CTL_SWCLK_BIT];
	assign clock_pin_toggle_strobe = wr_control && req.wdata[shift_unit_pkg::CTL_TOGGLE_BIT];

	// Clock source select; strobe bits in the written byte apply with it
	always_comb begin
		count_tick = 1'b0;
		shift_tick = 1'b0;
		if (req.wdata[shift_unit_pkg::CTL_EXT_BIT] && wr_control) begin
			// External source with strobe: counter ticks only when both clock and toggle strobes are written
			count_tick = software_clock_strobe && clock_pin_toggle_strobe;
		end else if (wr_control && !req.wdata[shift_unit_pkg::CTL_EXT_BIT]) begin
			count_tick = software_clock_strobe;
			shift_tick = software_clock_strobe;
		end
		if (external_clock_select) begin
			// Both edges count, one chosen edge samples data
			count_tick = count_tick || scl_rise || scl_fall;
			shift_tick = clock_edge_select ? scl_fall : scl_rise;
		end else if (serial_control[shift_unit_pkg::CTL_EDGE_BIT] && timer_match_i) begin
			count_tick = 1'b1;
			shift_tick = 1'b1;
		end
	end

	assign wrap_now = count_tick && edge_count == shift_unit_pkg::CNT_MAX;

	// ----------------------------------------
	// Shift register and counter
	// ----------------------------------------
	// No buffer: software reads and writes the shifter itself
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			shift_data <= shift_unit_pkg::RESET_BYTE;
		end else if (wr_data) begin
			shift_data <= req.wdata;
		end else if (shift_tick) begin
			shift_data <= {shift_data[6:0], sda_sync[1]};
		end
	end

	// Counter writes also beat a coincident tick
	always_comb begin
		next_count = edge_count;
		if (wr_status) begin
			next_count = req.wdata[3:0];
		end else if (count_tick) begin
			next_count = edge_count + 4'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			edge_count <= 4'h0;
		end else begin
			edge_count <= next_count;
		end
	end

	// ----------------------------------------
	// Flags and clock holds
	// ----------------------------------------
	// Start detector runs on the system clock; limitation: no wake with the clock stopped
	start_detector start_unit (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.enable_i(two_wire),
		.scl_i(scl_sync[1]),
		.sda_i(sda_sync[1]),
		.start_o(start_seen)
	);

	// Start flag: set wins over a write-one clear
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			start_detect_flag <= 1'b0;
		end else if (two_wire ? start_seen : count_tick) begin
			start_detect_flag <= 1'b1;
		end else if (wr_status && req.wdata[shift_unit_pkg::STAT_START_BIT]) begin
			start_detect_flag <= 1'b0;
		end
	end

	// Hold arms when the master pulls SCL low after a start
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			start_hold <= 1'b0;
		end else if (!two_wire || !start_detect_flag) begin
			start_hold <= 1'b0;
		end else if (scl_fall) begin
			start_hold <= 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			counter_wrap_flag <= 1'b0;
		end else if (wrap_now) begin
			counter_wrap_flag <= 1'b1;
		end else if (wr_status && req.wdata[shift_unit_pkg::STAT_WRAP_BIT]) begin
			counter_wrap_flag <= 1'b0;
		end
	end

	// Wrap hold only in the holding two-wire mode
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wrap_hold <= 1'b0;
		end else if (wire_mode_field != shift_unit_pkg::WM_TWO_HOLD || !counter_wrap_flag) begin
			wrap_hold <= 1'b0;
		end else begin
			wrap_hold <= 1'b1;
		end
	end

	// ----------------------------------------
	// Control and port registers
	// ----------------------------------------
	// Strobe bits are not stored; clock pin toggles on request
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			serial_control <= shift_unit_pkg::RESET_BYTE;
		end else if (wr_control) begin
			serial_control <= {req.wdata[7:2], 2'h0};
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			port_reg <= shift_unit_pkg::PORT_RESET;
		end else if (req.wr && req.addr == shift_unit_pkg::ADDR_PORT) begin
			port_reg <= req.wdata;
		end else if (clock_pin_toggle_strobe) begin
			port_reg[shift_unit_pkg::PORT_SCL_OUT_BIT] <= !port_reg[shift_unit_pkg::PORT_SCL_OUT_BIT];
		end
	end

	// ----------------------------------------
	// Output latch and pins
	// ----------------------------------------
	// External clock: open in first half, i.e. while clock is in its sampling phase
	assign latch_open = !external_clock_select || (clock_edge_select ? scl_sync[1] : !scl_sync[1]);

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			out_latch <= 1'b1;
		end else if (latch_open) begin
			out_latch <= shift_data[7];
		end
	end

	assign data_out_o = out_latch;

	// Two-wire mode is open drain, three-wire drives both levels; software sets the direction per byte
	always_comb begin
		sda_o = 1'b0;
		scl_o = 1'b0;
		sda_oe_n_o = 1'b1;
		scl_oe_n_o = 1'b1;
		scl_pin_level = port_reg[shift_unit_pkg::PORT_SCL_OUT_BIT];
		if (two_wire) begin
			sda_oe_n_o = !(port_reg[shift_unit_pkg::PORT_SDA_DIR_BIT]
				&& (!out_latch || !port_reg[shift_unit_pkg::PORT_SDA_OUT_BIT]));
			scl_oe_n_o = !((port_reg[shift_unit_pkg::PORT_SCL_DIR_BIT] && !scl_pin_level)
				|| start_hold || wrap_hold);
		end else if (wire_mode_field == shift_unit_pkg::WM_THREE) begin
			sda_o = out_latch;
			sda_oe_n_o = !port_reg[shift_unit_pkg::PORT_SDA_DIR_BIT];
			scl_o = scl_pin_level;
			scl_oe_n_o = !port_reg[shift_unit_pkg::PORT_SCL_DIR_BIT];
		end
	end

	// Interrupt requests with global enable
	assign start_irq_o = start_detect_flag && serial_control[shift_unit_pkg::CTL_START_IE_BIT]
		&& port_reg[shift_unit_pkg::PORT_GIE_BIT];
	assign wrap_irq_o = counter_wrap_flag && serial_control[shift_unit_pkg::CTL_WRAP_IE_BIT]
		&& port_reg[shift_unit_pkg::PORT_GIE_BIT];

	// ----------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= shift_unit_pkg::RESET_BYTE;
		end else if (req.rd) begin
			case (req.addr)
				shift_unit_pkg::ADDR_DATA: reg_rdata_o <= shift_data;
				shift_unit_pkg::ADDR_STATUS: reg_rdata_o <= {start_detect_flag, counter_wrap_flag, 1'b0,
					two_wire && (shift_data[7] != sda_sync[1]), edge_count};
				shift_unit_pkg::ADDR_CONTROL: reg_rdata_o <= serial_control;
				default: reg_rdata_o <= port_reg;
			endcase
		end else begin
			reg_rdata_o <= shift_unit_pkg::RESET_BYTE;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	write_wins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_data |=> shift_data == $past(reg_wdata_i))
		else $error("data write lost to a shift");

	wrap_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(count_tick && !wr_status && edge_count == shift_unit_pkg::CNT_MAX)
		|=> counter_wrap_flag && edge_count == 4'h0)
		else $error("wrap flag not set on 15 to 0");

	wrap_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wire_mode_field == shift_unit_pkg::WM_TWO_HOLD && counter_wrap_flag) [*2] |-> !scl_oe_n_o)
		else $error("clock not held after wrap");

	start_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_status && reg_wdata_i[shift_unit_pkg::STAT_START_BIT] && !start_seen && !count_tick)
		|=> !start_detect_flag)
		else $error("start flag not cleared by write one");

	start_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(two_wire && start_seen) |=> start_detect_flag)
		else $error("start flag missed");

	sda_pull_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(two_wire && port_reg[shift_unit_pkg::PORT_SDA_DIR_BIT] && !out_latch) |-> !sda_oe_n_o && !sda_o)
		else $error("data line not pulled low");

	irq_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		start_irq_o |-> start_detect_flag && serial_control[shift_unit_pkg::CTL_START_IE_BIT])
		else $error("start interrupt without flag");

	count_edge_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(external_clock_select && scl_rise && !wr_status && !wr_control) |=> edge_count == $past(edge_count) + 4'h1)
		else $error("external edge not counted");

endmodule // universal_shift_unit

// ===== dv/two_wire_master_model.sv
// ----------------------------------------
// Two-wire bus master, behavioural
// ----------------------------------------
module two_wire_master_model (
	output logic scl_drive_o,
	output logic sda_drive_o,
	input wire logic scl_line_i,
	output logic stall_err_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Lines released; the pull-ups hold them high
	initial begin
		scl_drive_o = 1'b1;
		sda_drive_o = 1'b1;
		stall_err_o = 1'b0;
	end

	// Data falls while clock high, then clock pulled low
	task automatic start_cond();
		#1;
		sda_drive_o = 1'b0;
		#250;
		scl_drive_o = 1'b0;
		#62.5;
	endtask

	// Idle pulse on data only, clock left high
	task automatic data_blip();
		#1;
		sda_drive_o = 1'b0;
		#250;
		sda_drive_o = 1'b1;
	endtask

	// MSB first; data changes only while the clock is low
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sda_drive_o = b[i];
			#62.5;
			scl_drive_o = 1'b1;
			// Slave may stretch: wait until the line is really high
			for (int n = 0; n < 200 && scl_line_i !== 1'b1; n++) begin
				#10;
			end
			if (scl_line_i !== 1'b1) begin
				stall_err_o = 1'b1;
			end
			#62.5;
			scl_drive_o = 1'b0;
		end
		sda_drive_o = 1'b1;
	endtask

	// One clock pulse with data released, for the acknowledge bit
	task automatic ack_clock();
		sda_drive_o = 1'b1;
		#62.5;
		scl_drive_o = 1'b1;
		for (int n = 0; n < 200 && scl_line_i !== 1'b1; n++) begin
			#10;
		end
		if (scl_line_i !== 1'b1) begin
			stall_err_o = 1'b1;
		end
		#62.5;
		scl_drive_o = 1'b0;
	endtask
endmodule // two_wire_master_model

// ===== dv/universal_serial_shift_two_wire_tb_top.sv
module universal_serial_shift_two_wire_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] reg_addr_i = 2'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic timer_match_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
	logic data_out_o, start_irq_o, wrap_irq_o;
	logic scl_drv, sda_drv, stall_err;
	wire logic scl_line;
	wire logic sda_line;
	int err_total = 0;
	int check_count = 0;
	logic [7:0] rv;

	// Open-drain wires with pull-ups
	assign scl_line = scl_drv & (scl_oe_n_o | scl_o);
	assign sda_line = sda_drv & (sda_oe_n_o | sda_o);

	always #5 clock_i = ~clock_i;

	universal_shift_unit u_dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .timer_match_i(timer_match_i),
		.scl_i(scl_line), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
		.data_out_o(data_out_o), .start_irq_o(start_irq_o), .wrap_irq_o(wrap_irq_o)
	);

	two_wire_master_model u_master (
		.scl_drive_o(scl_drv), .sda_drive_o(sda_drv),
		.scl_line_i(scl_line), .stall_err_o(stall_err)
	);

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
		check_count++;
		if ((got & mask) !== (exp & mask)) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp}, 8'h01);
	endtask

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		rd(2'h0, rv); check8(rv, 8'h00, 8'hFF);
		rd(2'h1, rv); check8(rv, 8'h00, 8'hEF);
		rd(2'h2, rv); check8(rv, 8'h00, 8'hFF);
		rd(2'h3, rv); check8(rv, 8'h03, 8'hFF);
		@(posedge clock_i);
		#1 check8(reg_rdata_o, 8'h00, 8'hFF);
		$display("test reset done");
	endtask

	// Strobe shift pulls a one from the idle data line
	task automatic test_soft_shift();
		wr(2'h0, 8'hA5);
		rd(2'h0, rv); check8(rv, 8'hA5, 8'hFF);
		wr(2'h2, 8'h02);
		rd(2'h0, rv); check8(rv, 8'h4B, 8'hFF);
		rd(2'h1, rv); check8(rv, 8'h81, 8'hEF);
		$display("test soft_shift done");
	endtask

	task automatic test_wrap();
		wr(2'h1, 8'hCF);
		wr(2'h3, 8'h13);
		wr(2'h2, 8'h42);
		rd(2'h1, rv); check8(rv, 8'hC0, 8'hEF);
		check1(wrap_irq_o, 1'b1);
		wr(2'h1, 8'h40);
		rd(2'h1, rv); check8(rv, 8'h80, 8'hEF);
		check1(wrap_irq_o, 1'b0);
		wr(2'h3, 8'h03);
		$display("test wrap done");
	endtask

	// Timer clocking; a coincident write wins over the shift
	task automatic test_timer();
		wr(2'h2, 8'h04);
		wr(2'h0, 8'h81);
		@(posedge clock_i);
		timer_match_i <= 1'b1;
		@(posedge clock_i);
		timer_match_i <= 1'b0;
		rd(2'h0, rv); check8(rv, 8'h03, 8'hFF);
		@(posedge clock_i);
		timer_match_i <= 1'b1;
		reg_addr_i <= 2'h0;
		reg_wdata_i <= 8'h3C;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		timer_match_i <= 1'b0;
		reg_wr_i <= 1'b0;
		rd(2'h0, rv); check8(rv, 8'h3C, 8'hFF);
		$display("test timer done");
	endtask

	task automatic test_sda_pull();
		wr(2'h2, 8'h20);
		wr(2'h3, 8'h07);
		wr(2'h0, 8'h7F);
		repeat (3) @(posedge clock_i);
		check1(sda_oe_n_o, 1'b0);
		check1(data_out_o, 1'b0);
		wr(2'h0, 8'h80);
		repeat (3) @(posedge clock_i);
		check1(sda_oe_n_o, 1'b1);
		check1(data_out_o, 1'b1);
		wr(2'h3, 8'h03);
		$display("test sda_pull done");
	endtask

	// Start shape with outputs off must not be seen
	task automatic test_no_start_off();
		wr(2'h2, 8'h00);
		wr(2'h1, 8'hC0);
		u_master.data_blip();
		repeat (20) @(posedge clock_i);
		rd(2'h1, rv); check8(rv, 8'h00, 8'h80);
		$display("test no_start_off done");
	endtask

	// Slave receive: start, hold, byte, wrap hold
	task automatic test_two_wire();
		int n;
		wr(2'h0, 8'hFF);
		wr(2'h3, 8'h0B);
		wr(2'h2, 8'h38);
		wr(2'h1, 8'hC0);
		u_master.start_cond();
		rv = 8'h00;
		for (n = 0; n < 20 && rv[7] !== 1'b1; n++) begin
			rd(2'h1, rv);
		end
		check8(rv, 8'h80, 8'h80);
		check1(scl_oe_n_o, 1'b0);
		wr(2'h1, 8'h80);
		@(posedge clock_i);
		#1 check1(scl_oe_n_o, 1'b1);
		u_master.send_byte(8'hA6);
		repeat (10) @(posedge clock_i);
		check1(stall_err, 1'b0);
		check1(scl_oe_n_o, 1'b0);
		rd(2'h1, rv); check8(rv, 8'h40, 8'hCF);
		rd(2'h0, rv); check8(rv, 8'hA6, 8'hFF);
		wr(2'h1, 8'h40);
		@(posedge clock_i);
		#1 check1(scl_oe_n_o, 1'b1);
		wr(2'h1, 8'h0E);
		u_master.ack_clock();
		repeat (10) @(posedge clock_i);
		check1(stall_err, 1'b0);
		check1(scl_oe_n_o, 1'b0);
		rd(2'h1, rv); check8(rv, 8'h40, 8'hCF);
		$display("test two_wire done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		test_reset();
		test_soft_shift();
		test_wrap();
		test_timer();
		test_sda_pull();
		test_no_start_off();
		test_two_wire();
		complete_run();
	end

	// A hang counts as a mismatch
	initial begin
		#500000;
		err_total++;
		$display("unexpected at %0t: run did not finish", $time);
		complete_run();
	end
endmodule // universal_serial_shift_two_wire_tb_top
